// *** hw/avmm_regs.v ***
// Purpose: Avalon-MM slave holding the sequencer control, status and fault registers.
// Assumes: 32-bit data, one aligned word per register, byte enables honoured on writes.
// Notes:   Waitrequest is high in the request cycle and low one cycle later.
`timescale 1ns/10ps
`include "park_seq_regs.vh"
module avmm_regs (
	// Clock and reset
	input  wire                mclk_i,
	input  wire                sys_rst_i,
	// Avalon-MM slave
	input  wire [`ADDR_W-1:0]  avs_address_i,
	input  wire                avs_read_i,
	input  wire                avs_write_i,
	input  wire [31:0]         avs_writedata_i,
	input  wire [3:0]          avs_byteenable_i,
	output reg  [31:0]         avs_readdata_o,
	output reg                 avs_waitrequest_o,
	// Sequencer side
	output reg  [2:0]          ctrl_o,
	output reg                 restart_pulse_o,
	output reg                 fault_clr_o,
	output reg  [2:0]          fault_clr_bits_o,
	input  wire [3:0]          state_i,
	input  wire [7:0]          status_i,
	input  wire [2:0]          fault_i
);
	reg ack;
	wire req = (avs_read_i || avs_write_i) && !ack;

	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ack               <= 1'b0;
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h0000_0000;
			ctrl_o            <= 3'h0;
			restart_pulse_o   <= 1'b0;
			fault_clr_o       <= 1'b0;
			fault_clr_bits_o  <= 3'h0;
		end else begin
			ack               <= req;
			avs_waitrequest_o <= !req;
			restart_pulse_o   <= 1'b0;
			fault_clr_o       <= 1'b0;
			if (req && avs_write_i && avs_byteenable_i[0]) begin
				case (avs_address_i)
					`REG_CTRL: begin
						ctrl_o[`CTRL_POWER_ON]   <= avs_writedata_i[`CTRL_POWER_ON];
						ctrl_o[`CTRL_BIAS_FIRST] <= avs_writedata_i[`CTRL_BIAS_FIRST];
						restart_pulse_o          <= avs_writedata_i[`CTRL_RESTART];
					end
					`REG_FAULT: begin
						fault_clr_o      <= 1'b1;
						fault_clr_bits_o <= avs_writedata_i[2:0];
					end
					default: begin
					end
				endcase
			end
			if (req && avs_read_i) begin
				case (avs_address_i)
					`REG_CTRL:   avs_readdata_o <= {29'h0, ctrl_o};
					`REG_STATUS: avs_readdata_o <= {20'h0, status_i, state_i};
					`REG_FAULT:  avs_readdata_o <= {29'h0, fault_i};
					default:     avs_readdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // avmm_regs

// *** hw/mirror_array_power_sequencer.v ***
// Purpose: Host-side power sequencer for a micromirror array and its digital controller.
// Assumes: 10 MHz clock; power-good and discharge inputs synchronous to it.
// Notes:   Software orders power on/off and restart through an Avalon-MM register block.
// How it works
// - Core and I/O supplies come up and report good before any high-voltage enable rises.
// - Bias may lead or trail offset on power-up, selected by a control bit.
// - The mirror-reset supply is enabled together with the later of bias and offset.
// - All single-ended controller inputs stay low until core and I/O are good.
// - A planned power-down asserts the park request for at least 500 us first.
// - On input power loss the park request rises at once and supplies stay on 500 us.
// - Restart after parking holds the controller reset low for 50 ms, then releases it.
// - Core and I/O stay on until all high-voltage rails report discharged; the code also moves on when the discharge timer expires.
// - On power-down offset may be removed while bias is still falling.
// - Discharged means bias and offset at most 4.0 V and reset in -4.0 V to 0.5 V.
// - Hardware power-down drives the power-down line low and drops rails only after parking.
// - Software power-down also drops the rails only after parking completes.
// - Offset leads bias on power-up and bias is removed before offset on power-down; the code lets a control bit put bias first on power-up.
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
`include "park_seq_regs.vh"
module mirror_array_power_sequencer #(
	parameter PARK_CYC      = `PARK_HOLD_CYC,
	parameter CTRL_RST_CYC  = `CTRL_RST_HOLD_CYC,
	parameter SETTLE_CYC    = `SETTLE_CYC,
	parameter DISCHARGE_CYC = `DISCHARGE_CYC,
	parameter TW            = 20
) (
	// Clock and reset
	input  wire               mclk_i,
	input  wire               sys_rst_i,
	// Avalon-MM slave
	input  wire [`ADDR_W-1:0] avs_address_i,
	input  wire               avs_read_i,
	input  wire               avs_write_i,
	input  wire [31:0]        avs_writedata_i,
	input  wire [3:0]         avs_byteenable_i,
	output wire [31:0]        avs_readdata_o,
	output wire               avs_waitrequest_o,
	// Supply monitors
	input  wire               core_good_i,
	input  wire               io_good_i,
	input  wire               hv_discharged_i,
	input  wire               input_power_lost_i,
	// Supply enables
	output reg                core_supply_en_o,
	output reg                io_supply_en_o,
	output reg                offset_en_o,
	output reg                bias_en_o,
	output reg                mirror_reset_en_o,
	// Controller pins
	output reg                mirror_park_request_o,
	output reg                controller_reset_n_o,
	output reg                hw_powerdown_n_o,
	output reg                cmos_inputs_enable_o
);
	wire [2:0] ctrl;
	wire       restart_pulse;
	wire       fault_clr;
	wire [2:0] fault_clr_bits;
	reg  [3:0] state;
	reg  [3:0] next_state;
	reg  [2:0] fault;
	reg        hw_down;
	reg        restart_pend;
	reg        tmr_load;
	reg  [TW-1:0] tmr_count;
	wire       tmr_done;
	wire       core_ok = core_good_i && io_good_i;
	wire [7:0] status = {3'h0, hw_down, restart_pend, core_ok, hv_discharged_i,
		mirror_park_request_o};

	avmm_regs u_regs (
		.mclk_i            (mclk_i),
		.sys_rst_i         (sys_rst_i),
		.avs_address_i     (avs_address_i),
		.avs_read_i        (avs_read_i),
		.avs_write_i       (avs_write_i),
		.avs_writedata_i   (avs_writedata_i),
		.avs_byteenable_i  (avs_byteenable_i),
		.avs_readdata_o    (avs_readdata_o),
		.avs_waitrequest_o (avs_waitrequest_o),
		.ctrl_o            (ctrl),
		.restart_pulse_o   (restart_pulse),
		.fault_clr_o       (fault_clr),
		.fault_clr_bits_o  (fault_clr_bits),
		.state_i           (state),
		.status_i          (status),
		.fault_i           (fault)
	);

	seq_timer #(.WIDTH(TW)) u_timer (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.load_i    (tmr_load),
		.count_i   (tmr_count),
		.done_o    (tmr_done)
	);

	// A power loss overrides software: it forces the park path from offset-up, bias-up and run; core-up goes straight to core-down.
	wire go_down = !ctrl[`CTRL_POWER_ON] || input_power_lost_i;

	// Core and I/O rails are up in every state but off and the restart hold.
	function core_rail_on;
		input [3:0] s;
		begin
			core_rail_on = (s != `ST_OFF) && (s != `ST_RESTART);
		end
	endfunction

	// Controller pins leave their low level only once the core rails have settled,
	// so a supply that never reports good keeps every pin low.
	function pins_free;
		input [3:0] s;
		input       good;
		begin
			pins_free = good && core_rail_on(s) && (s != `ST_CORE_UP);
		end
	endfunction

	// Sticky fault events; a clear in the same cycle loses to the event.
	wire [2:0] fault_event = {input_power_lost_i && state == `ST_RUN,
		state == `ST_DISCHARGE && tmr_done && !hv_discharged_i,
		state == `ST_CORE_UP && tmr_done && !core_ok && go_down};

	always @* begin
		next_state = state;
		tmr_load   = 1'b0;
		tmr_count  = {TW{1'b0}};
		case (state)
			`ST_OFF: begin
				if (ctrl[`CTRL_POWER_ON] && !input_power_lost_i) begin
					next_state = `ST_CORE_UP;
					tmr_load   = 1'b1;
					tmr_count  = SETTLE_CYC[TW-1:0];
				end
			end
			`ST_CORE_UP: begin
				if (go_down) begin
					next_state = `ST_CORE_DN;
				end else if (core_ok && tmr_done) begin
					next_state = `ST_OFFSET_UP;
					tmr_load   = 1'b1;
					tmr_count  = SETTLE_CYC[TW-1:0];
				end
			end
			`ST_OFFSET_UP: begin
				if (go_down) begin
					next_state = `ST_PARK;
					tmr_load   = 1'b1;
					tmr_count  = PARK_CYC[TW-1:0];
				end else if (tmr_done) begin
					next_state = `ST_BIAS_UP;
					tmr_load   = 1'b1;
					tmr_count  = SETTLE_CYC[TW-1:0];
				end
			end
			`ST_BIAS_UP: begin
				if (go_down) begin
					next_state = `ST_PARK;
					tmr_load   = 1'b1;
					tmr_count  = PARK_CYC[TW-1:0];
				end else if (tmr_done) begin
					next_state = `ST_RUN;
				end
			end
			`ST_RUN: begin
				if (go_down) begin
					next_state = `ST_PARK;
					tmr_load   = 1'b1;
					tmr_count  = PARK_CYC[TW-1:0];
				end
			end
			`ST_PARK: begin
				if (tmr_done) begin
					next_state = `ST_BIAS_DN;
					tmr_load   = 1'b1;
					tmr_count  = SETTLE_CYC[TW-1:0];
				end
			end
			`ST_BIAS_DN: begin
				if (tmr_done) begin
					next_state = `ST_OFFSET_DN;
				end
			end
			`ST_OFFSET_DN: begin
				next_state = `ST_DISCHARGE;
				tmr_load   = 1'b1;
				tmr_count  = DISCHARGE_CYC[TW-1:0];
			end
			`ST_DISCHARGE: begin
				if (hv_discharged_i || tmr_done) begin
					next_state = `ST_CORE_DN;
				end
			end
			`ST_CORE_DN: begin
				if (!ctrl[`CTRL_POWER_ON] || restart_pend) begin
					next_state = restart_pend ? `ST_RESTART : `ST_OFF;
					tmr_load   = 1'b1;
					tmr_count  = CTRL_RST_CYC[TW-1:0];
				end
			end
			`ST_RESTART: begin
				if (tmr_done) begin
					next_state = `ST_OFF;
				end
			end
			default: begin
				next_state = `ST_OFF;
			end
		endcase
	end

	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			state        <= `ST_OFF;
			fault        <= 3'h0;
			hw_down      <= 1'b0;
			restart_pend <= 1'b0;
		end else begin
			state <= next_state;
			fault <= (fault & ~(fault_clr ? fault_clr_bits : 3'h0)) | fault_event;
			if (restart_pulse && mirror_park_request_o) begin
				restart_pend <= 1'b1;
			end else if (next_state == `ST_RESTART) begin
				restart_pend <= 1'b0;
			end
			if (input_power_lost_i && state != `ST_OFF) begin
				hw_down <= 1'b1;
			end else if (next_state == `ST_OFF) begin
				hw_down <= 1'b0;
			end
		end
	end

	// Rail enables follow the state being entered, so each rail moves in the same
	// cycle as the step that owns it.
	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			core_supply_en_o  <= 1'b0;
			io_supply_en_o    <= 1'b0;
			offset_en_o       <= 1'b0;
			bias_en_o         <= 1'b0;
			mirror_reset_en_o <= 1'b0;
		end else begin
			core_supply_en_o <= core_rail_on(next_state);
			io_supply_en_o   <= core_rail_on(next_state);
			// Default order keeps offset ahead of bias; the control bit swaps them.
			if (next_state == `ST_OFFSET_UP) begin
				offset_en_o <= !ctrl[`CTRL_BIAS_FIRST];
				bias_en_o   <= ctrl[`CTRL_BIAS_FIRST];
			end else if (next_state == `ST_BIAS_UP) begin
				offset_en_o       <= 1'b1;
				bias_en_o         <= 1'b1;
				mirror_reset_en_o <= 1'b1;
			end else if (next_state == `ST_BIAS_DN) begin
				bias_en_o         <= 1'b0;
				mirror_reset_en_o <= 1'b0;
			end else if (next_state == `ST_DISCHARGE || next_state == `ST_OFFSET_DN) begin
				offset_en_o <= 1'b0;
				bias_en_o   <= 1'b0;
			end else if (next_state == `ST_CORE_DN || next_state == `ST_OFF) begin
				offset_en_o       <= 1'b0;
				bias_en_o         <= 1'b0;
				mirror_reset_en_o <= 1'b0;
			end
		end
	end

	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			mirror_park_request_o <= 1'b0;
			controller_reset_n_o  <= 1'b0;
			hw_powerdown_n_o      <= 1'b0;
			cmos_inputs_enable_o  <= 1'b0;
		end else begin
			// Park stays asserted from the first park cycle until the restart hold or the off state is entered.
			if (next_state == `ST_PARK) begin
				mirror_park_request_o <= 1'b1;
			end else if (next_state == `ST_RESTART || next_state == `ST_OFF) begin
				mirror_park_request_o <= 1'b0;
			end
			// Once a hardware power-down has begun the line stays low until off, even
			// if the input power comes back during the park span.
			hw_powerdown_n_o     <= !hw_down && pins_free(next_state, core_ok)
				&& !(next_state == `ST_PARK && input_power_lost_i);
			controller_reset_n_o <= pins_free(next_state, core_ok);
			cmos_inputs_enable_o <= pins_free(next_state, core_ok);
		end
	end
endmodule // mirror_array_power_sequencer

// *** hw/park_seq_regs.vh ***
// Purpose: Constants for the mirror array power sequencer and its register port.
// Assumes: 10 MHz clock (100 ns period).
// Notes:   Register offsets are byte addresses on a 32-bit Avalon-MM slave.
`ifndef PARK_SEQ_REGS_VH
`define PARK_SEQ_REGS_VH

`define CLK_PERIOD_NS        100
`define PARK_HOLD_US         500
`define CTRL_RST_HOLD_MS     50
`define SETTLE_US            1000
`define DISCHARGE_US         10000
`define PARK_HOLD_CYC        ((`PARK_HOLD_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CTRL_RST_HOLD_CYC    ((`CTRL_RST_HOLD_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CYC           ((`SETTLE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DISCHARGE_CYC        ((`DISCHARGE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define ADDR_W               4
`define REG_CTRL             4'h0
`define REG_STATUS           4'h4
`define REG_FAULT            4'h8

`define CTRL_POWER_ON        0
`define CTRL_RESTART         1
`define CTRL_BIAS_FIRST      2

`define ST_OFF               4'h0
`define ST_CORE_UP           4'h1
`define ST_OFFSET_UP         4'h2
`define ST_BIAS_UP           4'h3
`define ST_RUN               4'h4
`define ST_PARK              4'h5
`define ST_BIAS_DN           4'h6
`define ST_OFFSET_DN         4'h7
`define ST_DISCHARGE         4'h8
`define ST_CORE_DN           4'h9
`define ST_RESTART           4'hA

`define FAULT_CORE_TMO       0
`define FAULT_DISCH_TMO      1
`define FAULT_POWER_LOSS     2

`endif

// *** hw/seq_timer.v ***
// Purpose: Down-counting timer that reports expiry after a loaded number of cycles.
// Assumes: Load and count are exclusive; load wins.
// Notes:   Expiry stays high until the next load.
`timescale 1ns/10ps
module seq_timer #(
	parameter WIDTH = 20
) (
	// Clock and reset
	input  wire             mclk_i,
	input  wire             sys_rst_i,
	// Control
	input  wire             load_i,
	input  wire [WIDTH-1:0] count_i,
	output wire             done_o
);
	reg [WIDTH-1:0] remain;

	always @(posedge mclk_i) begin
		if (sys_rst_i) begin
			remain <= {WIDTH{1'b0}};
		end else if (load_i) begin
			remain <= count_i;
		end else if (remain != {WIDTH{1'b0}}) begin
			remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// Expiry does not look at load: the sequencer builds load from this output, and a
	// path back through it would close a combinational loop.
	assign done_o = (remain == {WIDTH{1'b0}});
endmodule // seq_timer

// *** test/mirror_array_power_sequencer_tb.sv ***
// Purpose: Self-checking bench for the mirror array power sequencer.
// Assumes: Short timing parameters keep the run small.
// Notes:   Register reads are compared with a bench register model.
`timescale 1ns/10ps
`include "park_seq_regs.vh"
module mirror_array_power_sequencer_tb;
	localparam PARK = 50;
	localparam RST_LOW = 50;
	reg         mclk_i = 1'b0;
	reg         sys_rst_i = 1'b1;
	reg  [3:0]  avs_address_i = 4'h0;
	reg         avs_read_i = 1'b0;
	reg         avs_write_i = 1'b0;
	reg  [31:0] avs_writedata_i = 32'h0;
	reg  [3:0]  avs_byteenable_i = 4'hF;
	reg         input_power_lost_i = 1'b0;
	reg         slow = 1'b0;
	wire [31:0] avs_readdata_o;
	wire        avs_waitrequest_o, core_good_i, io_good_i, hv_discharged_i;
	wire        core_supply_en_o, io_supply_en_o, offset_en_o, bias_en_o;
	wire        mirror_reset_en_o, mirror_park_request_o, controller_reset_n_o;
	wire        hw_powerdown_n_o, cmos_inputs_enable_o;
	integer     n_mismatch = 0;
	integer     total_checks = 0;
	integer     cyc = 0;
	integer     t_off, t_bias, t_pk, t_drop, t_rlo, t_rhi, i, k;
	reg         oe_q = 1'b0;
	reg         be_q = 1'b0;
	reg         pk_q = 1'b0;
	reg         rst_q = 1'b0;
	reg  [31:0] r;
	reg  [31:0] ctrl_m;
	always #50 mclk_i = ~mclk_i;
	mirror_array_power_sequencer #(.PARK_CYC(PARK), .CTRL_RST_CYC(RST_LOW), .SETTLE_CYC(20),
		.DISCHARGE_CYC(40), .TW(20)) i_dut (.*);
	supply_model i_sup (.mclk_i(mclk_i), .slow_i(slow), .core_en_i(core_supply_en_o),
		.io_en_i(io_supply_en_o), .hv_en_i(offset_en_o | bias_en_o | mirror_reset_en_o),
		.core_good_o(core_good_i), .io_good_o(io_good_i), .hv_discharged_o(hv_discharged_i));
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		oe_q <= offset_en_o;
		be_q <= bias_en_o;
		pk_q <= mirror_park_request_o;
		if (offset_en_o && !oe_q) t_off <= cyc;
		if (bias_en_o && !be_q) t_bias <= cyc;
		if (mirror_park_request_o && !pk_q) t_pk <= cyc;
		if (!bias_en_o && be_q) t_drop <= cyc;
		rst_q <= controller_reset_n_o;
		if (!controller_reset_n_o && rst_q) t_rlo <= cyc;
		if (controller_reset_n_o && !rst_q) t_rhi <= cyc;
	end
	task check(input [127:0] nm, input [31:0] seen, input [31:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task bus(input w, input [3:0] a, input [31:0] d);
		integer n;
		begin
			avs_address_i <= a;
			avs_writedata_i <= d;
			avs_write_i <= w;
			avs_read_i <= !w;
			@(posedge mclk_i);
			n = 0;
			while (avs_waitrequest_o !== 1'b0 && n < 50) begin
				@(posedge mclk_i);
				n = n + 1;
			end
			r = avs_readdata_o;
			if (n == 50) n_mismatch = n_mismatch + 1;
			avs_write_i <= 1'b0;
			avs_read_i <= 1'b0;
			@(posedge mclk_i);
		end
	endtask
	task wait_st(input [3:0] s);
		begin
			i = 0;
			bus(1'b0, `REG_STATUS, 32'h0);
			while (r[3:0] !== s && i < 300) begin
				bus(1'b0, `REG_STATUS, 32'h0);
				i = i + 1;
			end
			check("state", {28'h0, r[3:0]}, {28'h0, s});
		end
	endtask
	task summarize;
		begin
			$display("checks %0d mismatches %0d", total_checks, n_mismatch);
			if (n_mismatch == 0 && total_checks > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	initial begin
		repeat (20000) @(posedge mclk_i);
		n_mismatch = n_mismatch + 1;
		summarize;
	end
	initial begin
		i = $urandom(32'h1B23);
		repeat (6) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		@(posedge mclk_i);
		check("pins", {23'h0, cmos_inputs_enable_o, hw_powerdown_n_o, controller_reset_n_o,
			mirror_park_request_o, mirror_reset_en_o, bias_en_o, offset_en_o,
			io_supply_en_o, core_supply_en_o}, 32'h0);
		bus(1'b0, `REG_STATUS, 32'h0);
		check("status", r & 32'hFF, 32'h20);
		bus(1'b0, 4'hC, 32'h0);
		check("unmapped", r, 32'h0);
		avs_byteenable_i <= 4'h0;
		bus(1'b1, `REG_CTRL, 32'h1);
		avs_byteenable_i <= 4'hF;
		bus(1'b0, `REG_CTRL, 32'h0);
		check("ctrl_be", r, 32'h0);
		for (k = 0; k < 2; k = k + 1) begin
			slow <= $urandom % 2;
			ctrl_m = k ? 32'h5 : 32'h1;
			bus(1'b1, `REG_CTRL, ctrl_m);
			wait_st(`ST_RUN);
			check("run", {28'h0, r[7:4]}, 32'h4);
			check("order", {31'h0, t_off < t_bias}, {31'h0, k == 0});
			if (k == 0) begin
				bus(1'b1, `REG_CTRL, 32'h0);
				wait_st(`ST_OFF);
				check("core_off", {31'h0, core_supply_en_o}, 32'h0);
			end else begin
				repeat ($urandom % 8) @(posedge mclk_i);
				input_power_lost_i <= 1'b1;
				repeat (4) @(posedge mclk_i);
				check("park", {30'h0, mirror_park_request_o, hw_powerdown_n_o}, 32'h2);
				bus(1'b0, `REG_FAULT, 32'h0);
				check("fault", r, 32'h4);
				input_power_lost_i <= 1'b0;
				wait_st(`ST_CORE_DN);
				check("core_hold", {31'h0, core_supply_en_o}, 32'h1);
				bus(1'b1, `REG_CTRL, ($urandom & 32'hFFFF_FFF8) | 32'h0000_0007);
				bus(1'b0, `REG_CTRL, 32'h0);
				check("ctrl", r, ctrl_m);
				wait_st(`ST_RUN);
				check("restart", {31'h0, t_rhi - t_rlo >= RST_LOW}, 32'h1);
				bus(1'b1, `REG_FAULT, 32'h4);
				bus(1'b0, `REG_FAULT, 32'h0);
				check("fault_clr", r, 32'h0);
			end
			check("park_span", {31'h0, t_drop - t_pk >= PARK}, 32'h1);
		end
		summarize;
	end
endmodule // mirror_array_power_sequencer_tb

// *** test/seq_asserts.sv ***
// Purpose: Port-level timing checks for the power sequencer.
// Assumes: Bound to the sequencer top with its timing parameters.
// Notes:   Helper counters measure the park and reset-low spans.
`timescale 1ns/10ps
`include "park_seq_regs.vh"
module seq_asserts #(
	parameter PARK_CYC     = 50,
	parameter CTRL_RST_CYC = 50
) (
	// Clock, reset and bus
	input wire mclk_i,
	input wire sys_rst_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire avs_waitrequest_o,
	input wire [3:0]  avs_address_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0]  avs_byteenable_i,
	// Monitors and pins
	input wire input_power_lost_i,
	input wire core_good_i,
	input wire io_good_i,
	input wire core_supply_en_o,
	input wire io_supply_en_o,
	input wire offset_en_o,
	input wire bias_en_o,
	input wire mirror_reset_en_o,
	input wire mirror_park_request_o,
	input wire controller_reset_n_o,
	input wire hw_powerdown_n_o,
	input wire cmos_inputs_enable_o
);
	wire        hv_on = offset_en_o | bias_en_o | mirror_reset_en_o;
	reg  [19:0] park_cnt;
	reg  [19:0] low_cnt;
	reg         rn_q;
	reg         rs;
	// A restart write taken while parked arms rs; the next reset release must end a full
	// low span.
	always @(posedge mclk_i) begin
		rn_q <= controller_reset_n_o;
		if (sys_rst_i || !mirror_park_request_o)
			park_cnt <= 20'h00000;
		else
			park_cnt <= park_cnt + 20'h00001;
		if (sys_rst_i || controller_reset_n_o)
			low_cnt <= 20'h00000;
		else
			low_cnt <= low_cnt + 20'h00001;
		if (sys_rst_i)
			rs <= 1'b0;
		else if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
			&& avs_address_i == `REG_CTRL && avs_writedata_i[`CTRL_RESTART]
			&& mirror_park_request_o)
			rs <= 1'b1;
		else if (controller_reset_n_o && !rn_q)
			rs <= 1'b0;
	end
	chk_hv_after_good: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		hv_on |-> core_supply_en_o && io_supply_en_o && core_good_i && io_good_i)
		else $error("high-voltage rail on without settled core and io");
	chk_cmos_after_good: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		cmos_inputs_enable_o |-> core_good_i && io_good_i)
		else $error("cmos inputs enabled before core and io settled");
	chk_pins_after_good: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		controller_reset_n_o || hw_powerdown_n_o |-> core_good_i && io_good_i)
		else $error("controller pin released before core and io settled");
	chk_park_before_drop: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		$fell(bias_en_o) || $fell(offset_en_o) || $fell(mirror_reset_en_o)
		|-> park_cnt >= PARK_CYC)
		else $error("rail dropped before the park span ended");
	chk_loss_parks: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		input_power_lost_i && offset_en_o && bias_en_o && mirror_reset_en_o
		|-> ##[1:3] mirror_park_request_o)
		else $error("power loss did not raise the park request");
	chk_loss_powerdown: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		input_power_lost_i && mirror_park_request_o |-> ##[0:2] !hw_powerdown_n_o)
		else $error("power loss did not drive the power-down line low");
	chk_core_after_hv: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		$fell(core_supply_en_o) || $fell(io_supply_en_o) |-> !hv_on && !$past(hv_on))
		else $error("core or io removed while a high-voltage rail was on");
	chk_bias_before_offset: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		$fell(offset_en_o) |-> !bias_en_o)
		else $error("offset removed while bias still enabled");
	chk_restart_low: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		rs && $rose(controller_reset_n_o) |-> low_cnt >= CTRL_RST_CYC)
		else $error("controller reset pulse too short");
	chk_bus_answer: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		(avs_read_i || avs_write_i) && avs_waitrequest_o |-> ##1 !avs_waitrequest_o)
		else $error("bus request not answered one cycle later");
endmodule // seq_asserts

bind mirror_array_power_sequencer seq_asserts #(
	.PARK_CYC(PARK_CYC),
	.CTRL_RST_CYC(CTRL_RST_CYC)
) i_chk (
	.mclk_i                (mclk_i),
	.sys_rst_i             (sys_rst_i),
	.avs_read_i            (avs_read_i),
	.avs_write_i           (avs_write_i),
	.avs_waitrequest_o     (avs_waitrequest_o),
	.avs_address_i         (avs_address_i),
	.avs_writedata_i       (avs_writedata_i),
	.avs_byteenable_i      (avs_byteenable_i),
	.input_power_lost_i    (input_power_lost_i),
	.core_good_i           (core_good_i),
	.io_good_i             (io_good_i),
	.core_supply_en_o      (core_supply_en_o),
	.io_supply_en_o        (io_supply_en_o),
	.offset_en_o           (offset_en_o),
	.bias_en_o             (bias_en_o),
	.mirror_reset_en_o     (mirror_reset_en_o),
	.mirror_park_request_o (mirror_park_request_o),
	.controller_reset_n_o  (controller_reset_n_o),
	.hw_powerdown_n_o      (hw_powerdown_n_o),
	.cmos_inputs_enable_o  (cmos_inputs_enable_o)
);

// *** test/supply_model.sv ***
// Purpose: Supply and array model that reports settle and discharge.
// Assumes: Enables come from the sequencer; speed is chosen by the bench.
// Notes:   Slow mode stays inside the sequencer settle and discharge limits.
`timescale 1ns/10ps
module supply_model (
	// Clock and speed
	input  wire mclk_i,
	input  wire slow_i,
	// Enables
	input  wire core_en_i,
	input  wire io_en_i,
	input  wire hv_en_i,
	// Reports
	output reg  core_good_o = 1'b0,
	output reg  io_good_o = 1'b0,
	output reg  hv_discharged_o = 1'b1
);
	reg  [5:0] cc = 6'h00;
	reg  [5:0] ic = 6'h00;
	reg  [5:0] hc = 6'h3F;
	wire [5:0] dly = slow_i ? 6'h0F : 6'h02;
	// Rails may come and go in any order among bias, offset and reset.
	always @(posedge mclk_i) begin
		cc <= core_en_i ? cc + {5'h00, cc < dly} : 6'h00;
		ic <= io_en_i ? ic + {5'h00, ic < dly} : 6'h00;
		hc <= hv_en_i ? 6'h00 : hc + {5'h00, hc < {dly[4:0], 1'b0}};
		core_good_o <= core_en_i && cc >= dly;
		io_good_o <= io_en_i && ic >= dly;
		hv_discharged_o <= !hv_en_i && hc >= {dly[4:0], 1'b0};
	end
endmodule // supply_model
